// ### clock_mode_ctrl.v
/*
 * Clock mode controller: set/clear/status registers with keyed bits,
 * a test mode register, and selection of core and low-frequency
 * clocks among slow crystal, master oscillator, divider and PLL.
 * Assumes source clocks arrive as pins far slower than MCLK, so that
 * they can be sampled; the PLL itself sits outside and is only steered.
 */
// Our own choices: the plain strobed port and the address map.
// Operation
// - set address: ones in written data set stored bits
// - clear address: ones in written data clear stored bits
// - status address reads back current stored bits
// - keyed bits change only with matching key in same write
// - test enable changes only when key field equals D64A
// - D64A0002 enables test mode, D64A0000 disables it
// - 23050080 to set address sets slow oscillator enable
// - 18070080 to clear address clears slow oscillator enable
// - low power: master, PLL, divider off; both clocks from slow crystal
// - low power: slow clock keeps feeding timers and interrupt logic
// - slow mode: PLL off; core is master or master divided 2..256
// - operational: master and PLL run; core is PLL, multiply 2..20
// - slow/operational: low clock is slow crystal or divided master
`timescale 1ns/10ps
`include "clock_mode_defines.vh"
module clock_mode_ctrl #(
  parameter SLOW_STABLE_CYCLES = `SLOW_STABLE_CYCLES,
  parameter STABLE_WIDTH = 25
) (
  input wire MCLK,
  input wire RST_N,
  input wire [7:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [31:0] RDATA,
  input wire SLOW_CRYSTAL_CLOCK,
  input wire MASTER_OSC_CLOCK,
  input wire PLL_CLOCK,
  output reg CORE_SYSTEM_CLOCK,
  output reg LOW_FREQ_PERIPHERAL_CLOCK,
  output reg SLOW_OSC_ENABLE,
  output reg MASTER_OSC_ENABLE,
  output reg PLL_ENABLE,
  output reg [4:0] PLL_MULTIPLIER,
  output reg TEST_MODE
);
  // one-hot working modes
  localparam LOW_POWER_STATE = 3'h1;
  localparam DIVIDED_MASTER_STATE = 3'h2;
  localparam PLL_RUN_STATE = 3'h4;

  reg [1:0] rst_sync_reg;
  wire rst_n = rst_sync_reg[1];
  reg [2:0] sync1_reg;
  reg [2:0] sync2_reg;
  reg [2:0] sync3_reg;
  reg [2:0] filt_reg;
  reg mosc_prev_reg;
  reg [7:0] ctl_reg;
  reg [7:0] ctl_next;
  reg test_mode_enable_bit_reg;
  reg [2:0] mode_reg;
  reg [2:0] mode_next;
  reg [8:0] div_reg;
  reg [4:0] mul_reg;
  reg [1:0] core_cur_reg;
  reg core_park_reg;
  reg [1:0] lf_cur_reg;
  reg lf_park_reg;
  reg [1:0] core_want;
  reg [1:0] lf_want;
  reg div_run_reg;
  reg [STABLE_WIDTH-1:0] stable_cnt_reg;
  reg slow_stable_reg;
  wire div_level;
  wire [3:0] levels;
  wire [8:0] beta;
  wire [8:0] alpha;
  wire set_key_ok = (WDATA[31:16] == `SET_KEY);
  wire clear_key_ok = (WDATA[31:16] == `CLEAR_KEY);
  wire is_low = mode_reg[0];
  wire is_slow = mode_reg[1];
  wire is_oper = mode_reg[2];

  // restrict a factor to its legal range
  function [8:0] clamp;
    input [8:0] val;
    input [8:0] lo;
    input [8:0] hi;
    begin
      if (val < lo) begin
        clamp = lo;
      end else if (val > hi) begin
        clamp = hi;
      end else begin
        clamp = val;
      end
    end
  endfunction

  // level of the source named by a selection code
  function src_level;
    input [1:0] sel;
    input [3:0] lv;
    begin
      src_level = lv[sel];
    end
  endfunction

  // true when a selection uses the given source
  function uses;
    input [1:0] sel;
    input [1:0] src;
    begin
      uses = (sel == src);
    end
  endfunction

  assign beta = clamp(div_reg, `DIV_MIN, `DIV_MAX);
  assign alpha = clamp({4'h0, mul_reg}, `MUL_MIN, `MUL_MAX);
  assign levels = {filt_reg[2], div_level, filt_reg[1], filt_reg[0]};

  // reset release through two flops
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // source clocks pass three flops; accept when the last two agree
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync3_reg <= 3'h0;
      filt_reg <= 3'h0;
      mosc_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= {PLL_CLOCK, MASTER_OSC_CLOCK, SLOW_CRYSTAL_CLOCK};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg <= (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg ^ sync3_reg));
      mosc_prev_reg <= filt_reg[1];
    end
  end

  // next value of the clock status bits
  always @* begin
    ctl_next = ctl_reg;
    if (WR && ADDR == `OFF_CLK_SET) begin
      ctl_next = ctl_reg | (WDATA[7:0] & `CTL_FREE_MASK);
      if (set_key_ok) begin
        ctl_next = ctl_next | (WDATA[7:0] & `CTL_KEYED_MASK);
      end
    end else if (WR && ADDR == `OFF_CLK_CLEAR) begin
      ctl_next = ctl_reg & ~(WDATA[7:0] & `CTL_FREE_MASK);
      if (clear_key_ok) begin
        ctl_next = ctl_next & ~(WDATA[7:0] & `CTL_KEYED_MASK);
      end
    end
  end

  // next working mode; unknown codes leave the mode alone
  always @* begin
    mode_next = mode_reg;
    if (WR && ADDR == `OFF_MODE) begin
      case (WDATA[1:0])
        `MODE_CODE_LOW: begin
          mode_next = LOW_POWER_STATE;
        end
        `MODE_CODE_SLOW: begin
          mode_next = DIVIDED_MASTER_STATE;
        end
        `MODE_CODE_OPER: begin
          mode_next = PLL_RUN_STATE;
        end
        default: begin
          mode_next = mode_reg;
        end
      endcase
    end
  end

  // register writes
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      ctl_reg <= `CTL_RESET;
      test_mode_enable_bit_reg <= 1'b0;
      mode_reg <= LOW_POWER_STATE;
      div_reg <= `DIV_RESET;
      mul_reg <= `MUL_RESET;
    end else begin
      ctl_reg <= ctl_next;
      mode_reg <= mode_next;
      if (WR && ADDR == `OFF_TEST_MODE && WDATA[31:16] == `TEST_KEY) begin
        test_mode_enable_bit_reg <= WDATA[`TEST_EN_BIT];
      end
      if (WR && ADDR == `OFF_DIV) begin
        div_reg <= WDATA[8:0];
      end
      if (WR && ADDR == `OFF_PLL_MUL) begin
        mul_reg <= WDATA[4:0];
      end
    end
  end

  // wanted sources for each working mode
  always @* begin
    core_want = `SRC_SLOW;
    lf_want = `SRC_SLOW;
    case (mode_reg)
      LOW_POWER_STATE: begin
        core_want = `SRC_SLOW;
        lf_want = `SRC_SLOW;
      end
      DIVIDED_MASTER_STATE: begin
        core_want = ctl_reg[`CTL_CORE_DIV_BIT] ? `SRC_DIV : `SRC_MOSC;
        lf_want = ctl_reg[`CTL_LF_DIV_BIT] ? `SRC_DIV : `SRC_SLOW;
      end
      PLL_RUN_STATE: begin
        core_want = `SRC_PLL;
        lf_want = ctl_reg[`CTL_LF_DIV_BIT] ? `SRC_DIV : `SRC_SLOW;
      end
      default: begin
        core_want = `SRC_SLOW;
        lf_want = `SRC_SLOW;
      end
    endcase
  end

  // core clock switch: park low when the old source is low, leave
  // the park only when the new source is low, so no pulse is cut short
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      core_cur_reg <= `SRC_SLOW;
      core_park_reg <= 1'b0;
      CORE_SYSTEM_CLOCK <= 1'b0;
    end else begin
      if (!core_park_reg) begin
        if (core_want != core_cur_reg && !src_level(core_cur_reg, levels)) begin
          core_park_reg <= 1'b1;
          CORE_SYSTEM_CLOCK <= 1'b0;
        end else begin
          CORE_SYSTEM_CLOCK <= src_level(core_cur_reg, levels);
        end
      end else begin
        CORE_SYSTEM_CLOCK <= 1'b0;
        if (!src_level(core_want, levels)) begin
          core_cur_reg <= core_want;
          core_park_reg <= 1'b0;
        end
      end
    end
  end

  // low-frequency clock switch, same parking scheme
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      lf_cur_reg <= `SRC_SLOW;
      lf_park_reg <= 1'b0;
      LOW_FREQ_PERIPHERAL_CLOCK <= 1'b0;
    end else begin
      if (!lf_park_reg) begin
        if (lf_want != lf_cur_reg && !src_level(lf_cur_reg, levels)) begin
          lf_park_reg <= 1'b1;
          LOW_FREQ_PERIPHERAL_CLOCK <= 1'b0;
        end else begin
          LOW_FREQ_PERIPHERAL_CLOCK <= src_level(lf_cur_reg, levels);
        end
      end else begin
        LOW_FREQ_PERIPHERAL_CLOCK <= 1'b0;
        if (!src_level(lf_want, levels)) begin
          lf_cur_reg <= lf_want;
          lf_park_reg <= 1'b0;
        end
      end
    end
  end

  // source enables; a source stays on while a switch still uses it,
  // otherwise a stopped source held high would stall the park forever
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      SLOW_OSC_ENABLE <= 1'b1;
      MASTER_OSC_ENABLE <= 1'b0;
      PLL_ENABLE <= 1'b0;
      div_run_reg <= 1'b0;
      PLL_MULTIPLIER <= `MUL_RESET;
      TEST_MODE <= 1'b0;
    end else begin
      SLOW_OSC_ENABLE <= is_low | ctl_reg[`CTL_SLOW_EN_BIT]
        | uses(core_cur_reg, `SRC_SLOW) | uses(lf_cur_reg, `SRC_SLOW);
      MASTER_OSC_ENABLE <= !is_low | !uses(core_cur_reg, `SRC_SLOW)
        | !uses(lf_cur_reg, `SRC_SLOW);
      PLL_ENABLE <= is_oper | uses(core_cur_reg, `SRC_PLL);
      div_run_reg <= (!is_low & (uses(core_want, `SRC_DIV)
        | uses(lf_want, `SRC_DIV))) | uses(core_cur_reg, `SRC_DIV)
        | uses(lf_cur_reg, `SRC_DIV);
      PLL_MULTIPLIER <= alpha[4:0];
      TEST_MODE <= test_mode_enable_bit_reg;
    end
  end

  // master divider, counting sampled master rising edges
  edge_divider #(
    .WIDTH(9)
  ) u_divider (
    .clk(MCLK),
    .rst_n(rst_n),
    .run(div_run_reg),
    .edge_pulse(filt_reg[1] & ~mosc_prev_reg),
    .factor(beta),
    .level_reg(div_level)
  );

  // slow crystal settle time, counted from reset release
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      stable_cnt_reg <= {STABLE_WIDTH{1'b0}};
      slow_stable_reg <= 1'b0;
    end else if (!slow_stable_reg) begin
      if (stable_cnt_reg >= SLOW_STABLE_CYCLES[STABLE_WIDTH-1:0] - 1'b1) begin
        slow_stable_reg <= 1'b1;
      end else begin
        stable_cnt_reg <= stable_cnt_reg + {{(STABLE_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 32'h00000000;
    end else if (RD) begin
      if (ADDR == `OFF_TEST_MODE) begin
        RDATA <= {30'h0, test_mode_enable_bit_reg, 1'b0};
      end else if (ADDR == `OFF_CLK_STATUS) begin
        RDATA <= {24'h0, ctl_reg};
      end else if (ADDR == `OFF_MODE) begin
        RDATA <= {30'h0, is_oper, is_slow};
      end else if (ADDR == `OFF_DIV) begin
        RDATA <= {23'h0, div_reg};
      end else if (ADDR == `OFF_PLL_MUL) begin
        RDATA <= {27'h0, mul_reg};
      end else if (ADDR == `OFF_STATE) begin
        RDATA <= {21'h0, slow_stable_reg, lf_park_reg, core_park_reg,
          lf_cur_reg, core_cur_reg, 1'b0, mode_reg};
      end else begin
        RDATA <= 32'h00000000;
      end
    end else begin
      RDATA <= 32'h00000000;
    end
  end
endmodule

// ### clock_mode_defines.vh
/*
 * Register offsets, field positions, keys, reset values and timing
 * counts for the clock mode controller and its divider.
 * Assumes a 100 MHz register clock and an 8-bit register address.
 */
`ifndef CLOCK_MODE_DEFINES_VH
`define CLOCK_MODE_DEFINES_VH

// register byte offsets
`define OFF_TEST_MODE 8'h00
`define OFF_CLK_SET 8'h04
`define OFF_CLK_CLEAR 8'h08
`define OFF_CLK_STATUS 8'h0C
`define OFF_MODE 8'h10
`define OFF_DIV 8'h14
`define OFF_PLL_MUL 8'h18
`define OFF_STATE 8'h1C

// test mode register: key in the upper half, enable bit 1
`define TEST_KEY 16'hD64A
`define TEST_EN_BIT 1

// clock status bits and the keys that guard bit 7
`define CTL_LF_DIV_BIT 0
`define CTL_CORE_DIV_BIT 1
`define CTL_SLOW_EN_BIT 7
`define CTL_FREE_MASK 8'h03
`define CTL_KEYED_MASK 8'h80
`define CTL_RESET 8'h00
`define SET_KEY 16'h2305
`define CLEAR_KEY 16'h1807

// working mode codes as written to the mode register
`define MODE_CODE_LOW 2'h0
`define MODE_CODE_SLOW 2'h1
`define MODE_CODE_OPER 2'h2

// clock source selection codes
`define SRC_SLOW 2'h0
`define SRC_MOSC 2'h1
`define SRC_DIV 2'h2
`define SRC_PLL 2'h3

// divider and multiplier ranges and reset values
`define DIV_MIN 9'h002
`define DIV_MAX 9'h100
`define DIV_RESET 9'h002
`define MUL_MIN 9'h002
`define MUL_MAX 9'h014
`define MUL_RESET 5'h02

// timing
`define CLK_PERIOD_NS 10
`define RESET_HOLD_MS 5
`define SLOW_STABLE_MS 300
`define SLOW_STABLE_CYCLES (`SLOW_STABLE_MS * 1000000 / `CLK_PERIOD_NS)

`endif

// ### edge_divider.v
/*
 * Programmable divider for the sampled master oscillator.
 * Counts master rising-edge pulses made in the register clock domain;
 * the factor is already clamped by the caller to its legal range.
 */
`timescale 1ns/10ps
module edge_divider #(
  parameter WIDTH = 9
) (
  input wire clk,
  input wire rst_n,
  input wire run,
  input wire edge_pulse,
  input wire [WIDTH-1:0] factor,
  output reg level_reg
);
  reg [WIDTH-1:0] count_reg;
  wire [WIDTH-1:0] half = factor >> 1;

  // count master edges; high for the first half of each period
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= {WIDTH{1'b0}};
      level_reg <= 1'b0;
    end else if (!run) begin
      // stopped divider rests low so a clock switch can leave it
      count_reg <= {WIDTH{1'b0}};
      level_reg <= 1'b0;
    end else if (edge_pulse) begin
      if (count_reg >= factor - {{(WIDTH-1){1'b0}}, 1'b1}) begin
        count_reg <= {WIDTH{1'b0}};
        level_reg <= 1'b1;
      end else begin
        count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
        level_reg <= (count_reg + {{(WIDTH-1){1'b0}}, 1'b1}) < half;
      end
    end
  end
endmodule

// ### clock_mode_checker.sv
/*
 * Concurrent checks on the clock mode controller's ports.
 * Assumes the register master leaves one idle cycle after each strobe.
 */
`timescale 1ns/10ps
module clock_mode_checker (
  input wire MCLK,
  input wire RST_N,
  input wire [7:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [31:0] RDATA,
  input wire SLOW_CRYSTAL_CLOCK,
  input wire MASTER_OSC_CLOCK,
  input wire PLL_CLOCK,
  input wire CORE_SYSTEM_CLOCK,
  input wire LOW_FREQ_PERIPHERAL_CLOCK,
  input wire SLOW_OSC_ENABLE,
  input wire MASTER_OSC_ENABLE,
  input wire PLL_ENABLE,
  input wire [4:0] PLL_MULTIPLIER,
  input wire TEST_MODE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // read data only stands in the slot after a read strobe
  a_rdata_idle: assert property (
    !$past(RD) |-> RDATA == 32'h0)
    else $error("read data outside its slot");
  a_test_on: assert property (
    WR && ADDR == 8'h00 && WDATA == 32'hD64A0002 |-> ##2 TEST_MODE)
    else $error("test mode not entered");
  a_test_off: assert property (
    WR && ADDR == 8'h00 && WDATA == 32'hD64A0000 |-> ##2 !TEST_MODE)
    else $error("test mode not left");
  a_test_nokey: assert property (
    WR && ADDR == 8'h00 && WDATA[31:16] != 16'hD64A
    |-> ##2 $stable(TEST_MODE))
    else $error("test mode changed without key");
  // keyed set and clear seen through the next status read
  a_keyed_set: assert property (
    WR && ADDR == 8'h04 && WDATA == 32'h23050080 ##2 RD && ADDR == 8'h0C
    |=> RDATA[7])
    else $error("slow enable not set");
  a_keyed_clear: assert property (
    WR && ADDR == 8'h08 && WDATA == 32'h18070080 ##2 RD && ADDR == 8'h0C
    |=> !RDATA[7])
    else $error("slow enable not cleared");
  a_zero_keeps: assert property (
    RD && ADDR == 8'h0C ##2 WR && ADDR[7:4] == 4'h0 && WDATA[7:0] == 8'h00
    ##2 RD && ADDR == 8'h0C |=> RDATA[7:0] == $past(RDATA[7:0], 4))
    else $error("zero data bits changed status");
  a_nokey_keeps: assert property (
    RD && ADDR == 8'h0C ##2 WR && ADDR == 8'h04 && WDATA[31:16] != 16'h2305
    ##2 RD && ADDR == 8'h0C |=> RDATA[7] == $past(RDATA[7], 4))
    else $error("keyed bit set without key");
  a_lowp_stops: assert property (
    WR && ADDR == 8'h10 && WDATA[1:0] == 2'h0 |-> ##[1:400]
    (!PLL_ENABLE && !MASTER_OSC_ENABLE && SLOW_OSC_ENABLE))
    else $error("low power left sources running");
  a_slow_nopll: assert property (
    WR && ADDR == 8'h10 && WDATA[1:0] == 2'h1 |-> ##[1:400]
    (!PLL_ENABLE && MASTER_OSC_ENABLE))
    else $error("slow mode enables wrong");
  a_oper_runs: assert property (
    WR && ADDR == 8'h10 && WDATA[1:0] == 2'h2 |-> ##[1:400]
    (PLL_ENABLE && MASTER_OSC_ENABLE))
    else $error("operational mode enables wrong");
  a_mult_range: assert property (
    PLL_MULTIPLIER >= 5'h02 && PLL_MULTIPLIER <= 5'h14)
    else $error("multiplier out of range");
  // every source phase spans two cycles or more, so one is a glitch
  a_core_min_pulse: assert property (
    $changed(CORE_SYSTEM_CLOCK) |=> $stable(CORE_SYSTEM_CLOCK))
    else $error("core clock phase too short");
  a_lowf_min_pulse: assert property (
    $changed(LOW_FREQ_PERIPHERAL_CLOCK)
    |=> $stable(LOW_FREQ_PERIPHERAL_CLOCK))
    else $error("low clock phase too short");
endmodule
bind clock_mode_ctrl clock_mode_checker i_chk (.MCLK(MCLK), .RST_N(RST_N),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .SLOW_CRYSTAL_CLOCK(SLOW_CRYSTAL_CLOCK),
  .MASTER_OSC_CLOCK(MASTER_OSC_CLOCK), .PLL_CLOCK(PLL_CLOCK),
  .CORE_SYSTEM_CLOCK(CORE_SYSTEM_CLOCK),
  .LOW_FREQ_PERIPHERAL_CLOCK(LOW_FREQ_PERIPHERAL_CLOCK),
  .SLOW_OSC_ENABLE(SLOW_OSC_ENABLE), .MASTER_OSC_ENABLE(MASTER_OSC_ENABLE),
  .PLL_ENABLE(PLL_ENABLE), .PLL_MULTIPLIER(PLL_MULTIPLIER),
  .TEST_MODE(TEST_MODE));

// ### testbench.sv
/*
 * Self-checking bench for the clock mode controller.
 * Assumes source pins far slower than MCLK; periods are whole cycles.
 */
`timescale 1ns/10ps
`include "clock_mode_defines.vh"
module testbench;
  reg mclk, rst_n, wr_s, rd_s, slw, mst, pll;
  reg [7:0] addr;
  reg [31:0] wdata, d;
  wire [31:0] rdata;
  wire core, lowf, sen, men, pen, tm;
  wire [4:0] mul;
  integer num_errors, n_tests, cyc, p;
  clock_mode_ctrl #(.SLOW_STABLE_CYCLES(50)) i_dut (.MCLK(mclk),
    .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .SLOW_CRYSTAL_CLOCK(slw), .MASTER_OSC_CLOCK(mst),
    .PLL_CLOCK(pll), .CORE_SYSTEM_CLOCK(core),
    .LOW_FREQ_PERIPHERAL_CLOCK(lowf), .SLOW_OSC_ENABLE(sen),
    .MASTER_OSC_ENABLE(men), .PLL_ENABLE(pen), .PLL_MULTIPLIER(mul),
    .TEST_MODE(tm));
  // sources: slow 40, master 8, pll 4 cycles; edges on mclk falling edges, off the rising edges
  always #5 mclk = ~mclk;
  always #200 slw = ~slw;
  always #40 mst = ~mst;
  always #20 pll = ~pll;
  task report_and_stop;
    begin
      $display("tests %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // a hang anywhere ends the run as a mismatch
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      report_and_stop;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  // each access takes two cycles, so no strobe is raised twice at once
  task wr(input [7:0] a, input [31:0] v);
    begin
      wr_s <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge mclk);
      wr_s <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task rd(input [7:0] a, output [31:0] v);
    begin
      rd_s <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd_s <= 1'b0;
      @(negedge mclk);
      v = rdata;
      @(posedge mclk);
    end
  endtask
  task tmode(input [31:0] v, input e);
    begin
      wr(`OFF_TEST_MODE, v);
      rd(`OFF_TEST_MODE, d);
      chk(d, {30'h0, e, 1'b0});
      chk(tm, e);
    end
  endtask
  task sc(input [7:0] a, input [31:0] v, input [7:0] e);
    begin
      wr(a, v);
      rd(`OFF_CLK_STATUS, d);
      chk(d, {24'h0, e});
    end
  endtask
  // period in mclk cycles between two rising edges of one output clock
  task meas(input w, output integer n);
    time t;
    begin
      if (w) @(posedge lowf); else @(posedge core);
      t = $time;
      if (w) @(posedge lowf); else @(posedge core);
      n = ($time - t) / 10;
    end
  endtask
  task mode(input [1:0] m, input [1:0] st, input [7:0] cp,
            input [7:0] lp, input [1:0] en);
    begin
      wr(`OFF_CLK_CLEAR, 32'h00000003);
      wr(`OFF_CLK_SET, {30'h0, st});
      wr(`OFF_MODE, {30'h0, m});
      repeat (400) @(posedge mclk);
      meas(1'b0, p);
      chk(p, cp);
      meas(1'b1, p);
      chk(p, lp);
      chk({men, pen}, en);
    end
  endtask
  initial begin
    {mclk, rst_n, wr_s, rd_s, slw, mst, pll} = 7'h00;
    addr = 8'h00;
    wdata = 32'h00000000;
    {num_errors, n_tests, cyc} = 0;
    repeat (20) @(posedge mclk);
    chk({sen, men, pen, tm, mul}, {4'h8, 5'h02});
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(`OFF_STATE, d);
    chk(d & 32'h00000407, 32'h00000001);
    rd(`OFF_CLK_STATUS, d);
    chk(d, {24'h0, `CTL_RESET});
    rd(`OFF_DIV, d);
    chk(d, {23'h0, `DIV_RESET});
    rd(8'h20, d);
    chk(d, 32'h00000000);
    tmode(32'hD64A0002, 1'b1);
    tmode(32'h00000000, 1'b1);
    tmode(32'hD64B0000, 1'b1);
    tmode(32'hD64A0000, 1'b0);
    sc(`OFF_CLK_SET, 32'h00000003, 8'h03);
    sc(`OFF_CLK_SET, 32'h00000080, 8'h03);
    sc(`OFF_CLK_SET, 32'h23050080, 8'h83);
    sc(`OFF_CLK_CLEAR, 32'h00000080, 8'h83);
    sc(`OFF_CLK_CLEAR, 32'h00000001, 8'h82);
    sc(`OFF_CLK_CLEAR, 32'h18070080, 8'h02);
    sc(`OFF_CLK_SET, 32'h00000000, 8'h02);
    sc(`OFF_CLK_STATUS, 32'hFFFFFFFF, 8'h02);
    sc(`OFF_CLK_SET, 32'h23050080, 8'h82);
    wr(`OFF_DIV, 32'h00000004);
    mode(`MODE_CODE_LOW, 2'h3, 8'd40, 8'd40, 2'b00);
    mode(`MODE_CODE_SLOW, 2'h0, 8'd8, 8'd40, 2'b10);
    mode(`MODE_CODE_SLOW, 2'h3, 8'd32, 8'd32, 2'b10);
    mode(`MODE_CODE_OPER, 2'h1, 8'd4, 8'd32, 2'b11);
    wr(`OFF_MODE, 32'h00000003);
    rd(`OFF_MODE, d);
    chk(d, 32'h00000002);
    wr(`OFF_PLL_MUL, 32'h0000001F);
    rd(`OFF_PLL_MUL, d);
    chk(mul, 5'h14);
    wr(`OFF_PLL_MUL, 32'h00000008);
    rd(`OFF_PLL_MUL, d);
    chk(mul, 5'h08);
    mode(`MODE_CODE_LOW, 2'h1, 8'd40, 8'd40, 2'b00);
    rd(`OFF_STATE, d);
    chk(d[10], 1'b1);
    report_and_stop;
  end
endmodule
